// file: pid_governor_core.sv
// PID governor core with dual dynamics, fast gain and start limiter.
`timescale 1ns/100ps

module pid_governor_core #(
  parameter int SAMPLE_CYCLES = pid_gov_pkg::SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run_cmd,
  input wire logic grid_connected,
  input wire pid_gov_pkg::meas_t meas,
  input wire pid_gov_pkg::dyn_set_t speed_set,
  input wire pid_gov_pkg::dyn_set_t load_set,
  input wire pid_gov_pkg::tune_t tune,
  output logic [15:0] actuator_cmd,
  output logic start_limit_active,
  output logic deriv_feedback_mode,
  output logic load_dynamics_active,
  output logic fast_gain_active,
  output logic ratio_rejected
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic run_meta;    // First stage, read only by the second.
  logic run_s;       // Run command on the core clock.
  logic grid_meta;   // First stage, read only by the second.
  logic grid_s;      // Breaker state on the core clock.

  // Both discrete inputs come from contacts, hence two flops each.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_meta <= 1'b0;
      run_s <= 1'b0;
      grid_meta <= 1'b0;
      grid_s <= 1'b0;
    end else begin
      run_meta <= run_cmd;
      run_s <= run_meta;
      grid_meta <= grid_connected;
      grid_s <= grid_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sample divider
  // ----------------------------------------------------------------
  localparam logic [31:0] SAMPLE_LAST = 32'(SAMPLE_CYCLES - 1);
  logic [31:0] div_cnt;       // Counts down to the next sample.
  logic [31:0] next_div_cnt;
  logic tick;                 // One-cycle sample enable.
  logic next_tick;

  // All loop arithmetic advances only on tick, so the gains see a fixed period.
  always_comb begin
    next_tick = (div_cnt == 32'h0);
    next_div_cnt = next_tick ? SAMPLE_LAST : div_cnt - 32'h1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Active dynamics set and gain curves
  // ----------------------------------------------------------------
  pid_gov_pkg::dyn_set_t act_set;   // Set chosen by the breaker state.
  logic [2:0][pid_gov_pkg::CURVE_PTS-1:0][15:0] curve_pts;
  logic [2:0][15:0] curve_val;      // Interpolated kp, ki and ratio.

  always_comb begin
    act_set = grid_s ? load_set : speed_set;
    curve_pts[0] = act_set.kp_curve;
    curve_pts[1] = act_set.ki_curve;
    curve_pts[2] = act_set.ratio_curve;
  end

  // One interpolator per scheduled term.
  for (genvar g = 0; g < 3; g++) begin : g_curve
    gain_curve_interp u_interp (
      .gen_load(meas.gen_load),
      .points(curve_pts[g]),
      .value(curve_val[g])
    );
  end

  // ----------------------------------------------------------------
  // Loop arithmetic and start limiter
  // ----------------------------------------------------------------
  logic [15:0] ratio_q;              // Last accepted derivative ratio.
  logic [15:0] integ;                // Integrator, in actuator counts.
  logic [15:0] pv_prev;              // Process value at the previous sample.
  logic signed [47:0] sum_prev;      // Summing point at the previous sample.
  logic [15:0] limit_q;              // Limit seen with the current command.
  pid_gov_pkg::lim_state_t lim_state;
  logic [15:0] next_ratio, next_integ, next_pv_prev, next_cmd, next_limit;
  logic signed [47:0] next_sum_prev;
  pid_gov_pkg::lim_state_t next_lim_state;
  logic next_fb, next_load_dyn, next_fast, next_rej;

  logic [15:0] kp_sel, ki_sel, ratio_cand, ratio_use, limit16, cap, demand;
  logic ratio_ok, fast, fb, lim_on;
  logic signed [47:0] err, err_abs, dev, dev_abs, kp_eff, kd, p_term, d_term, integ_sum;

  // Clamp a signed value into 0..hi.
  function automatic logic [15:0] sat16(input logic signed [47:0] v, input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (v < 48'sh0) begin
      r = 16'h0;
    end else if (v > $signed({32'h0, hi})) begin
      r = hi;
    end
    return r;
  endfunction

  always_comb begin
    // Gain selection, single or scheduled over load.
    kp_sel = act_set.multi_gain ? curve_val[0] : act_set.kp;
    ki_sel = act_set.multi_gain ? curve_val[1] : act_set.ki;
    ratio_cand = act_set.multi_gain ? curve_val[2] : act_set.ratio;
    // An out-of-range ratio is refused and the last good one kept.
    ratio_ok = (ratio_cand <= pid_gov_pkg::RATIO_MAX);
    ratio_use = ratio_ok ? ratio_cand : ratio_q;
    // Positive error means process below setpoint, pushing output up.
    err = $signed({32'h0, meas.setpoint}) - $signed({32'h0, meas.process});
    err_abs = (err < 48'sh0) ? -err : err;
    dev = $signed({32'h0, meas.engine_speed}) - $signed({32'h0, meas.grid_freq});
    dev_abs = (dev < 48'sh0) ? -dev : dev;
    // Island: speed error against the window; grid: speed against grid frequency.
    fast = grid_s ? (dev_abs > $signed({32'h0, tune.fast_window}))
                  : (err_abs > $signed({32'h0, tune.fast_window}));
    kp_eff = $signed({32'h0, kp_sel});
    if (fast) begin
      kp_eff = (kp_eff * $signed({32'h0, tune.fast_ratio})) >>> pid_gov_pkg::GAIN_FRAC;
    end
    p_term = (kp_eff * err) >>> pid_gov_pkg::GAIN_FRAC;
    // Ratio r >= 1 gives weight 1/r, r < 1 gives weight r: reciprocals match.
    fb = (ratio_use >= pid_gov_pkg::RATIO_ONE);
    if (fb) begin
      kd = $signed({16'h0, pid_gov_pkg::RECIP_NUM / {16'h0, ratio_use}});
      // Feedback domain: oppose the change of the measured process value.
      d_term = -((kd * ($signed({32'h0, meas.process}) - $signed({32'h0, pv_prev})))
                 >>> pid_gov_pkg::GAIN_FRAC);
    end else begin
      kd = $signed({32'h0, ratio_use});
      // Input domain: differentiate the summing point ahead of the integrator.
      d_term = (kd * (p_term - sum_prev)) >>> pid_gov_pkg::GAIN_FRAC;
    end
    // Limit in actuator counts; 100 % or more switches the limiter off.
    lim_on = (tune.start_limit_pct < pid_gov_pkg::PCT_FULL);
    limit16 = lim_on ? 16'({9'h0, tune.start_limit_pct} * pid_gov_pkg::PCT_SCALE)
                     : pid_gov_pkg::ACT_FULL;
    // Integrator capped at the limit while armed so it cannot wind up.
    cap = (lim_state == pid_gov_pkg::LIM_ARMED) ? limit16 : pid_gov_pkg::ACT_FULL;
    integ_sum = $signed({32'h0, integ})
              + ((p_term * $signed({32'h0, ki_sel}))
                 >>> (pid_gov_pkg::GAIN_FRAC + pid_gov_pkg::INT_SHIFT));
    demand = sat16($signed({32'h0, sat16(integ_sum, cap)}) + p_term + d_term,
                   pid_gov_pkg::ACT_FULL);
    // Start limiter sequence.
    next_lim_state = lim_state;
    unique case (lim_state)
      pid_gov_pkg::LIM_OFF: begin
        if (run_s) begin
          next_lim_state = lim_on ? pid_gov_pkg::LIM_ARMED : pid_gov_pkg::LIM_PID;
        end
      end
      pid_gov_pkg::LIM_ARMED: begin
        // The PID is in control once its own demand sits below the clamp.
        if (!lim_on || (tick && demand < limit16)) begin
          next_lim_state = pid_gov_pkg::LIM_PID;
        end
      end
      pid_gov_pkg::LIM_PID: begin
        next_lim_state = pid_gov_pkg::LIM_PID;
      end
      default: begin
        next_lim_state = pid_gov_pkg::LIM_OFF;
      end
    endcase
    if (!run_s) begin
      next_lim_state = pid_gov_pkg::LIM_OFF;
    end
    // These registered values move on the sample tick only; lim_state and limit_q update every cycle.
    next_ratio = tick ? ratio_use : ratio_q;
    next_integ = tick ? sat16(integ_sum, cap) : integ;
    next_pv_prev = tick ? meas.process : pv_prev;
    next_sum_prev = tick ? p_term : sum_prev;
    next_cmd = tick ? demand : actuator_cmd;
    next_fb = tick ? fb : deriv_feedback_mode;
    next_load_dyn = tick ? grid_s : load_dynamics_active;
    next_fast = tick ? fast : fast_gain_active;
    next_rej = tick ? !ratio_ok : ratio_rejected;
    // Stopped engine: drop to zero travel and clear the integrator.
    if (!run_s) begin
      next_integ = 16'h0;
      next_cmd = 16'h0;
    end
    // The clamp is applied every cycle while armed, also on the arming edge.
    if (next_lim_state == pid_gov_pkg::LIM_ARMED && next_cmd > limit16) begin
      next_cmd = limit16;
    end
    next_limit = limit16;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ratio_q <= pid_gov_pkg::RATIO_RESET;
      integ <= 16'h0;
      pv_prev <= 16'h0;
      sum_prev <= 48'sh0;
      actuator_cmd <= 16'h0;
      limit_q <= pid_gov_pkg::ACT_FULL;
      lim_state <= pid_gov_pkg::LIM_OFF;
      deriv_feedback_mode <= 1'b1;
      load_dynamics_active <= 1'b0;
      fast_gain_active <= 1'b0;
      ratio_rejected <= 1'b0;
    end else begin
      ratio_q <= next_ratio;
      integ <= next_integ;
      pv_prev <= next_pv_prev;
      sum_prev <= next_sum_prev;
      actuator_cmd <= next_cmd;
      limit_q <= next_limit;
      lim_state <= next_lim_state;
      deriv_feedback_mode <= next_fb;
      load_dynamics_active <= next_load_dyn;
      fast_gain_active <= next_fast;
      ratio_rejected <= next_rej;
    end
  end

  // The one-hot armed bit is itself a flip-flop.
  assign start_limit_active = lim_state[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_arm_on_run: assert property (
    $rose(run_s) && tune.start_limit_pct < pid_gov_pkg::PCT_FULL |=> start_limit_active)
    else $error("limiter not armed after run rose");
  chk_limit_clamp: assert property (
    start_limit_active |-> actuator_cmd <= limit_q)
    else $error("command above start limit while armed");
  chk_limit_release: assert property (
    start_limit_active && run_s && tick && demand < limit16 |=> !start_limit_active)
    else $error("limiter kept after PID took control");
  chk_full_disables: assert property (
    tune.start_limit_pct >= pid_gov_pkg::PCT_FULL |=> !start_limit_active)
    else $error("limiter active at 100 percent");
  chk_out_range: assert property (
    actuator_cmd <= pid_gov_pkg::ACT_FULL && integ <= pid_gov_pkg::ACT_FULL)
    else $error("output or integrator beyond full travel");
  chk_ratio_range: assert property (
    tick && !ratio_ok |=> ratio_rejected && ratio_q == $past(ratio_q)
      && ratio_q <= pid_gov_pkg::RATIO_MAX)
    else $error("out-of-range ratio taken");
  chk_mode_select: assert property (
    tick && ratio_ok |=> deriv_feedback_mode == ($past(ratio_cand) >= pid_gov_pkg::RATIO_ONE))
    else $error("derivative domain does not follow ratio");
  chk_dyn_select: assert property (
    tick |=> load_dynamics_active == $past(grid_s))
    else $error("dynamics set does not follow breaker");
  chk_fast_island: assert property (
    tick && !grid_s && err_abs > $signed({32'h0, tune.fast_window}) |=> fast_gain_active)
    else $error("fast gain missing on large speed error");
  chk_sample_gap: assert property (
    tick |=> !tick)
    else $error("sample ticks back to back");

  cov_armed_release: cover property (start_limit_active ##1 !start_limit_active && run_s);
  cov_input_dom: cover property (tick ##1 !deriv_feedback_mode);
  cov_fast_grid: cover property (load_dynamics_active && fast_gain_active);
  cov_clamped: cover property (start_limit_active && actuator_cmd == limit_q);

endmodule

// file: pid_gov_pkg.sv
// Shared constants, types and state codes for the governor PID core.
package pid_gov_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;                  // Reference clock rate in MHz.
  localparam int SAMPLE_TIME_US = 1000;         // Control sample period in microseconds.
  localparam int SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_MHZ;  // Clocks per sample.

  // ----------------------------------------------------------------
  // Scaling of actuator travel, gains and the derivative ratio
  // ----------------------------------------------------------------
  localparam logic [15:0] ACT_FULL = 16'h2710;  // 10000 counts = 100.00 % travel.
  localparam logic [15:0] PCT_SCALE = 16'h0064; // Actuator counts per percent.
  localparam logic [6:0] PCT_FULL = 7'h64;      // A start limit of 100 % disables it.
  localparam int GAIN_FRAC = 8;                 // Gains and ratios are Q8.8.
  localparam logic [15:0] RATIO_ONE = 16'h0100; // Ratio 1.0, the domain boundary.
  localparam logic [15:0] RATIO_MAX = 16'h6400; // Ratio 100.0, the highest legal value.
  localparam logic [15:0] RATIO_RESET = 16'h0100; // Ratio held after reset.
  localparam logic [31:0] RECIP_NUM = 32'h0001_0000; // 1.0 in Q16.16 for 1/ratio.
  localparam int INT_SHIFT = 10;                // Integral step scale per sample.

  // ----------------------------------------------------------------
  // Load-scheduled gain curves
  // ----------------------------------------------------------------
  localparam int CURVE_PTS = 5;                 // Points per curve.
  localparam int SEG_FRAC = 14;                 // Load bits below the segment index.

  // One dynamics set: single gains plus the three 5-point curves.
  typedef struct packed {
    logic multi_gain;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] ratio;
    logic [CURVE_PTS-1:0][15:0] kp_curve;
    logic [CURVE_PTS-1:0][15:0] ki_curve;
    logic [CURVE_PTS-1:0][15:0] ratio_curve;
  } dyn_set_t;

  // Tuning common to both sets.
  typedef struct packed {
    logic [15:0] fast_window;
    logic [15:0] fast_ratio;
    logic [6:0] start_limit_pct;
  } tune_t;

  // Measured and reference values, all on the core clock.
  typedef struct packed {
    logic [15:0] setpoint;
    logic [15:0] process;
    logic [15:0] engine_speed;
    logic [15:0] grid_freq;
    logic [15:0] gen_load;
  } meas_t;

  // Start limiter states, one-hot.
  typedef enum logic [2:0] {
    LIM_OFF = 3'b001,
    LIM_ARMED = 3'b010,
    LIM_PID = 3'b100
  } lim_state_t;

endpackage

// file: gain_curve_interp.sv
// Linear interpolation of one 5-point gain curve over generator load.
`timescale 1ns/100ps

module gain_curve_interp (
  input wire logic [15:0] gen_load,
  input wire logic [pid_gov_pkg::CURVE_PTS-1:0][15:0] points,
  output logic [15:0] value
);

  // ----------------------------------------------------------------
  // Segment lookup and interpolation
  // ----------------------------------------------------------------
  logic [2:0] seg;              // Segment 0..3, the top two load bits.
  logic [13:0] frac;            // Position inside the segment.
  logic signed [31:0] span;     // Difference between the segment end points.
  logic signed [31:0] step;     // Scaled share of the span.

  // Full load lands just short of the last point; the error is one LSB of load.
  always_comb begin
    seg = {1'b0, gen_load[15:14]};
    frac = gen_load[pid_gov_pkg::SEG_FRAC-1:0];
    span = $signed({16'h0, points[seg + 3'h1]}) - $signed({16'h0, points[seg]});
    step = (span * $signed({18'h0, frac})) >>> pid_gov_pkg::SEG_FRAC;
    value = 16'($signed({16'h0, points[seg]}) + step);
  end

endmodule

// file: gov_plant_model.sv
// Behavioural engine, actuator and sensor model feeding the governor core.
`timescale 1ns/100ps

module gov_plant_model #(
  parameter int LAG_SHIFT = 3
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [15:0] actuator_cmd,
  input wire logic closed_loop,
  input wire logic [15:0] setpoint,
  input wire logic [15:0] process_open,
  input wire logic [15:0] engine_speed,
  input wire logic [15:0] grid_freq,
  input wire logic [15:0] gen_load,
  output pid_gov_pkg::meas_t meas
);
  // ----------------------------------------------------------------
  // Process value
  // ----------------------------------------------------------------
  logic [15:0] pv;            // Measured process value seen by the core.
  logic [15:0] next_pv;       // Value the process takes at the next edge.
  logic signed [17:0] gap;    // Actuator demand minus present process.

  // Closed loop, the process lags towards the actuator with a first-order response,
  // so a larger LAG_SHIFT gives a slower engine; open loop, the bench sets it directly.
  always_comb begin
    gap = $signed({2'b00, actuator_cmd}) - $signed({2'b00, pv});
    if (closed_loop) begin
      next_pv = pv + 16'(gap >>> LAG_SHIFT);
    end else begin
      next_pv = process_open;
    end
  end

  // Registering the process adds one clock of sensor delay, as a real transducer would.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pv <= 16'h0000;
    end else begin
      pv <= next_pv;
    end
  end

  // ----------------------------------------------------------------
  // Measurement bundle
  // ----------------------------------------------------------------
  always_comb begin
    meas.setpoint = setpoint;
    meas.process = pv;
    meas.engine_speed = engine_speed;
    meas.grid_freq = grid_freq;
    meas.gen_load = gen_load;
  end
endmodule

// file: pid_governor_core_test.sv
// Self-checking testbench for the governor PID core with its plant model.
`timescale 1ns/100ps

module pid_governor_core_test;
  localparam int SC = 10;  // Short sample period keeps the run brief.
  logic ref_clk;
  logic arst_n;
  logic run_cmd;
  logic grid_connected;
  logic closed_loop;
  logic [15:0] sp;
  logic [15:0] pv;
  logic [15:0] speed;
  logic [15:0] grid;
  logic [15:0] load;
  pid_gov_pkg::meas_t meas;
  pid_gov_pkg::dyn_set_t speed_set;
  pid_gov_pkg::dyn_set_t load_set;
  pid_gov_pkg::tune_t tune;
  logic [15:0] actuator_cmd;
  logic start_limit_active;
  logic deriv_feedback_mode;
  logic load_dynamics_active;
  logic fast_gain_active;
  logic ratio_rejected;
  int num_errors;
  int comparisons;
  int cyc;                 // Edges since reset release.
  logic [15:0] base;       // Command seen one sample earlier.
  logic [15:0] ratios [3] = '{16'h0100, 16'h0200, 16'h0080};
  logic [15:0] kicks [3] = '{16'h0100, 16'h0080, 16'h0080};
  logic modes [3] = '{1'b1, 1'b1, 1'b0};

  pid_governor_core #(.SAMPLE_CYCLES(SC)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .run_cmd(run_cmd), .grid_connected(grid_connected), .meas(meas), .speed_set(speed_set),
    .load_set(load_set), .tune(tune), .actuator_cmd(actuator_cmd),
    .start_limit_active(start_limit_active), .deriv_feedback_mode(deriv_feedback_mode),
    .load_dynamics_active(load_dynamics_active), .fast_gain_active(fast_gain_active),
    .ratio_rejected(ratio_rejected));

  gov_plant_model u_plant (.ref_clk(ref_clk), .arst_n(arst_n), .actuator_cmd(actuator_cmd),
    .closed_loop(closed_loop), .setpoint(sp), .process_open(pv), .engine_speed(speed),
    .grid_freq(grid), .gen_load(load), .meas(meas));

  // ----------------------------------------------------------------
  // Clock, edge count and helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  // Builds a single-gain dynamics set; the curves hold the same values for safety.
  function automatic pid_gov_pkg::dyn_set_t single(logic [15:0] kp, logic [15:0] ki,
                                                  logic [15:0] ratio);
    pid_gov_pkg::dyn_set_t s;
    s = '0;
    s.kp = kp;
    s.ki = ki;
    s.ratio = ratio;
    s.kp_curve = {5{kp}};
    s.ki_curve = {5{ki}};
    s.ratio_curve = {5{ratio}};
    return s;
  endfunction

  // Sample ticks land on edge 2 and then every SC edges; the edge seen is cyc plus one.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      while (cyc % SC != 1) @(posedge ref_clk);
    end
    #1;
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Dropping run clears the integrator, so every scenario starts from a known state.
  task automatic setup(input logic [15:0] kp, input logic [15:0] ki);
    run_cmd = 1'b0;
    speed_set = single(kp, ki, 16'h0100);
    tune.start_limit_pct = 7'h64;
    tick(2);
    run_cmd = 1'b1;
    tick(2);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few thousand edges the tests need.
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {run_cmd, grid_connected, closed_loop} = 3'b000;
    {sp, pv, speed, grid, load} = {16'h1000, 16'h0c00, 16'h1000, 16'h1000, 16'h0000};
    speed_set = single(16'h0100, 16'h0000, 16'h0100);
    load_set = single(16'h0200, 16'h0000, 16'h0100);
    tune = '{fast_window: 16'hffff, fast_ratio: 16'h0200, start_limit_pct: 7'h64};
    repeat (2) @(posedge ref_clk);
    #1;
    chk16("cmd_reset", 16'h0000, actuator_cmd);
    chk1("fb_mode_reset", 1'b1, deriv_feedback_mode);
    chk1("limit_reset", 1'b0, start_limit_active);
    arst_n = 1'b1;
    // Proportional term, direction and saturation.
    setup(16'h0100, 16'h0000);
    tick(3);
    chk16("cmd_p", 16'h0400, actuator_cmd);
    pv = 16'h1400;
    tick(3);
    chk16("cmd_above", 16'h0000, actuator_cmd);
    pv = 16'h0c00;
    speed_set.kp = 16'h4000;
    tick(3);
    chk16("cmd_full", 16'h2710, actuator_cmd);
    // Fast gain in island operation.
    speed_set.kp = 16'h0100;
    tune.fast_window = 16'h0100;
    tick(3);
    chk1("fast_on", 1'b1, fast_gain_active);
    chk16("cmd_fast", 16'h0800, actuator_cmd);
    pv = 16'h0f80;
    tick(3);
    chk1("fast_off", 1'b0, fast_gain_active);
    chk16("cmd_slow", 16'h0080, actuator_cmd);
    tune.fast_window = 16'hffff;
    // Derivative kick in both domains, gone one sample later.
    for (int i = 0; i < 3; i++) begin
      speed_set.ratio = ratios[i];
      pv = 16'h0c00;
      tick(3);
      chk1("fb_mode", modes[i], deriv_feedback_mode);
      pv = 16'h0b00;
      tick(1);
      chk16("cmd_kick", 16'h0500 + kicks[i], actuator_cmd);
      tick(1);
      chk16("cmd_settle", 16'h0500, actuator_cmd);
    end
    speed_set.ratio = 16'h6401;
    tick(2);
    chk1("ratio_refused", 1'b1, ratio_rejected);
    chk1("ratio_kept", 1'b0, deriv_feedback_mode);
    speed_set.ratio = 16'h6400;
    tick(2);
    chk1("ratio_taken", 1'b0, ratio_rejected);
    chk1("fb_mode_max", 1'b1, deriv_feedback_mode);
    // Load-scheduled curve, midway and on a point.
    pv = 16'h0c00;
    speed_set.multi_gain = 1'b1;
    speed_set.kp_curve = {16'h0300, 16'h0300, 16'h0300, 16'h0100, 16'h0100};
    load = 16'h6000;
    tick(3);
    chk16("cmd_curve_mid", 16'h0800, actuator_cmd);
    load = 16'h4000;
    tick(3);
    chk16("cmd_curve_pt", 16'h0400, actuator_cmd);
    // Grid operation selects the load set and its fast gain criterion.
    grid_connected = 1'b1;
    tune.fast_window = 16'h0100;
    tick(3);
    chk1("load_set_on", 1'b1, load_dynamics_active);
    chk1("grid_no_fast", 1'b0, fast_gain_active);
    chk16("cmd_load_set", 16'h0800, actuator_cmd);
    speed = 16'h1200;
    tick(3);
    chk1("grid_fast", 1'b1, fast_gain_active);
    chk16("cmd_grid_fast", 16'h1000, actuator_cmd);
    {speed, tune.fast_window, grid_connected} = {16'h1000, 16'hffff, 1'b0};
    tick(3);
    chk1("load_set_off", 1'b0, load_dynamics_active);
    // Integral step per sample with a constant error.
    setup(16'h0100, 16'h4000);
    pv = 16'h0800;
    tick(2);
    base = actuator_cmd;
    tick(1);
    chk16("integ_step", base + 16'h0080, actuator_cmd);
    // Closed loop: the integrator removes the offset left by the P term.
    setup(16'h0100, 16'hffff);
    // A full derivative on this fast plant would ring, so the weakest feedback-domain one, ratio 100.0, is used.
    speed_set.ratio = 16'h6400;
    closed_loop = 1'b1;
    tick(150);
    chk1("pv_settled", 1'b1, meas.process >= 16'h0fe0 && meas.process <= 16'h1020);
    closed_loop = 1'b0;
    // Start limiter arms on run, clamps, and lets go when the loop takes over.
    setup(16'h4000, 16'h0000);
    run_cmd = 1'b0;
    tune.start_limit_pct = 7'h1e;
    pv = 16'h0800;
    tick(2);
    run_cmd = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk1("limit_armed", 1'b1, start_limit_active);
    tick(3);
    chk1("limit_held", 1'b1, start_limit_active);
    chk16("cmd_clamped", 16'h0bb8, actuator_cmd);
    pv = 16'h1000;
    tick(2);
    chk1("limit_released", 1'b0, start_limit_active);
    setup(16'h4000, 16'h0000);
    pv = 16'h0800;
    repeat (4) @(posedge ref_clk);
    #1;
    chk1("limit_disabled", 1'b0, start_limit_active);
    tick(3);
    chk16("cmd_unlimited", 16'h2710, actuator_cmd);
    print_verdict();
  end
endmodule
